// ---- hdl/svh_port_end.sv ----
`timescale 1ns/100ps
`default_nettype none
module svh_port_end
  import svh_pkg::*;
(
  input wire logic clock_i, // 25 MHz
  input wire logic reset_i, // sync, active high
  input wire logic contract_i, // explicit contract in place
  input wire logic is_dfp_i, // data role is downstream facing
  input wire logic is_source_i, // power role is source
  input wire logic support_i, // structured messages supported
  input wire logic abort_i, // other sop sequence takes over
  input wire logic tx_valid_i, // send a header, one-cycle pulse
  input wire logic [15:0] tx_svid_i, // svid to send
  input wire logic [1:0] tx_ctype_i, // command type
  input wire logic [2:0] tx_obj_i, // object position
  input wire logic [4:0] tx_cmd_i, // command
  input wire logic [1:0] tx_sop_i, // packet kind
  output logic busy_o, // request waiting for response
  output logic tx_reject_o, // send refused, pulse
  output logic rx_valid_o, // accepted header, pulse
  output logic [15:0] rx_svid_o, // received svid
  output logic [1:0] rx_ctype_o, // received command type
  output logic [2:0] rx_obj_o, // received object position
  output logic [4:0] rx_cmd_o, // received command
  output logic [1:0] rx_ver_o, // received version
  output logic [1:0] rx_sop_o, // received packet kind
  output logic rx_drop_o, // received header discarded, pulse
  output logic exit_all_o, // exit of all modes asked, pulse
  svh_link_if.port_end link // toward partner
);

  typedef enum logic [0:0] {SVH_IDLE, SVH_WAIT} svh_state_t;
  svh_state_t state_q;

  logic tx_legal;
  logic early_disc;
  logic tx_go;
  logic rx_struct;
  logic rx_role_ok;
  logic rx_ok;
  logic [4:0] rx_cmd;
  logic [1:0] rx_ctype;
  logic [2:0] rx_obj;
  logic [1:0] pend_sop_q;
  logic [4:0] pend_cmd_q;
  logic req_go;
  logic resp_ok;

  // early cable discovery by a source needs no contract
  assign early_disc = is_source_i && tx_cmd_i == SVH_CMD_DISC_ID &&
                      tx_sop_i == SVH_SOP_P && tx_ctype_i == SVH_CT_INIT;

  always_comb begin
    tx_legal = 1'b0;
    if (tx_cmd_i != SVH_CMD_RSVD && obj_ok(tx_cmd_i, tx_obj_i)) begin
      if (tx_ctype_i == SVH_CT_INIT) begin
        if (tx_cmd_i == SVH_CMD_ATTN)
          tx_legal = !is_dfp_i && tx_sop_i == SVH_SOP;
        else
          tx_legal = is_dfp_i && state_q == SVH_IDLE;
      end else begin
        tx_legal = !is_dfp_i && tx_sop_i == SVH_SOP;
      end
    end
    if (!support_i)
      tx_legal = 1'b0;
    else if (!contract_i && !early_disc)
      tx_legal = 1'b0;
  end

  // abort also blocks a send in the same cycle, so nothing half-starts
  assign tx_go = tx_valid_i && tx_legal && !abort_i;

  // decode from fixed positions; reserved bits never looked at
  assign rx_struct = link.up_hdr[SVH_TYPE_BIT];
  assign rx_cmd = link.up_hdr[SVH_CMD_LSB +: 5];
  assign rx_ctype = link.up_hdr[SVH_CTYPE_LSB +: 2];
  assign rx_obj = link.up_hdr[SVH_OBJ_LSB +: 3];

  always_comb begin
    rx_role_ok = 1'b0;
    if (rx_ctype == SVH_CT_INIT) begin
      if (rx_cmd == SVH_CMD_ATTN)
        rx_role_ok = is_dfp_i && link.up_sop == SVH_SOP;
      else
        rx_role_ok = !is_dfp_i && link.up_sop == SVH_SOP;
    end else begin
      // a response must match the request in flight
      rx_role_ok = is_dfp_i && state_q == SVH_WAIT &&
                   rx_cmd == pend_cmd_q && link.up_sop == pend_sop_q;
    end
  end

  // while early discovery waits, its reply and an sop attention are the only uncontracted messages taken
  assign rx_ok = support_i && rx_struct && rx_role_ok &&
                 rx_cmd != SVH_CMD_RSVD && obj_ok(rx_cmd, rx_obj) &&
                 (contract_i || (state_q == SVH_WAIT && pend_cmd_q == SVH_CMD_DISC_ID &&
                  pend_sop_q == SVH_SOP_P)) && !abort_i;

  // only a request that expects an answer opens an exchange
  assign req_go = tx_go && tx_ctype_i == SVH_CT_INIT && tx_cmd_i != SVH_CMD_ATTN;
  // attention is fire and forget, so it never closes one either
  assign resp_ok = link.up_valid && rx_ok && rx_ctype != SVH_CT_INIT;

  // abort wins over both a new request and a late answer
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q <= SVH_IDLE;
    end else if (abort_i) begin
      state_q <= SVH_IDLE;
    end else begin
      unique case (state_q)
        SVH_IDLE: begin
          if (req_go)
            state_q <= SVH_WAIT;
        end
        SVH_WAIT: begin
          if (resp_ok)
            state_q <= SVH_IDLE;
        end
      endcase
    end
  end

  // what is in flight, so that an answer can be matched to it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pend_cmd_q <= SVH_CMD_RSVD;
      pend_sop_q <= SVH_SOP;
    end else if (req_go) begin
      pend_cmd_q <= tx_cmd_i;
      pend_sop_q <= tx_sop_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      link.dn_valid <= 1'b0;
      link.dn_hdr <= SVH_HDR_RESET;
      link.dn_sop <= SVH_SOP;
      tx_reject_o <= 1'b0;
    end else begin
      link.dn_valid <= tx_go;
      tx_reject_o <= tx_valid_i && !tx_go;
      if (tx_go) begin
        // replies always carry our own version, whatever came in
        link.dn_hdr <= svh_pack(tx_svid_i, tx_ctype_i, tx_obj_i, tx_cmd_i);
        link.dn_sop <= tx_sop_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_valid_o <= 1'b0;
      rx_drop_o <= 1'b0;
      exit_all_o <= 1'b0;
      rx_svid_o <= 16'h0000;
      rx_ctype_o <= SVH_CT_INIT;
      rx_obj_o <= SVH_OBJ_NONE;
      rx_cmd_o <= SVH_CMD_RSVD;
      rx_ver_o <= SVH_VER_1_0;
      rx_sop_o <= SVH_SOP;
    end else begin
      rx_valid_o <= link.up_valid && rx_ok;
      rx_drop_o <= link.up_valid && !rx_ok;
      exit_all_o <= link.up_valid && rx_ok && rx_cmd == SVH_CMD_EXIT &&
                    rx_obj == SVH_OBJ_EXIT_ALL;
      if (link.up_valid && rx_ok) begin
        rx_svid_o <= link.up_hdr[SVH_SVID_LSB +: 16];
        rx_ctype_o <= rx_ctype;
        rx_obj_o <= rx_obj;
        rx_cmd_o <= rx_cmd;
        rx_ver_o <= link.up_hdr[SVH_VER_LSB +: 2];
        rx_sop_o <= link.up_sop;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i)
      busy_o <= 1'b0;
    else
      // loaded from the next state, so the flag matches state_q cycle for cycle and never lags the exchange
      busy_o <= !abort_i && (state_q == SVH_WAIT || req_go) &&
                !resp_ok;
  end

endmodule : svh_port_end
`default_nettype wire

// ---- hdl/svh_pkg.sv ----
package svh_pkg;

  // header field positions
  localparam int unsigned SVH_SVID_LSB = 16;
  localparam int unsigned SVH_TYPE_BIT = 15;
  localparam int unsigned SVH_VER_LSB = 13;
  localparam int unsigned SVH_OBJ_LSB = 8;
  localparam int unsigned SVH_CTYPE_LSB = 6;
  localparam int unsigned SVH_CMD_LSB = 0;

  localparam logic [1:0] SVH_VER_1_0 = 2'h0;
  localparam logic [1:0] SVH_VER_SUPPORTED = SVH_VER_1_0;
  localparam logic [15:0] SVH_PD_SID = 16'hff00;

  localparam logic [2:0] SVH_OBJ_NONE = 3'h0;
  localparam logic [2:0] SVH_OBJ_EXIT_ALL = 3'h7;

  localparam logic [4:0] SVH_CMD_RSVD = 5'h00;
  localparam logic [4:0] SVH_CMD_DISC_ID = 5'h01;
  localparam logic [4:0] SVH_CMD_DISC_SVIDS = 5'h02;
  localparam logic [4:0] SVH_CMD_DISC_MODES = 5'h03;
  localparam logic [4:0] SVH_CMD_ENTER = 5'h04;
  localparam logic [4:0] SVH_CMD_EXIT = 5'h05;
  localparam logic [4:0] SVH_CMD_ATTN = 5'h06;

  localparam logic [1:0] SVH_CT_INIT = 2'h0;
  localparam logic [1:0] SVH_CT_ACK = 2'h1;
  localparam logic [1:0] SVH_CT_NAK = 2'h2;
  localparam logic [1:0] SVH_CT_BUSY = 2'h3;

  localparam logic [1:0] SVH_SOP = 2'h0;
  localparam logic [1:0] SVH_SOP_P = 2'h1;
  localparam logic [1:0] SVH_SOP_PP = 2'h2;

  localparam logic [31:0] SVH_HDR_RESET = 32'h0000_0000;

  function automatic logic uses_obj(input logic [4:0] cmd);
    return (cmd == SVH_CMD_ENTER) || (cmd == SVH_CMD_EXIT);
  endfunction : uses_obj

  // reserved bits 12:11 and 5 always go out as zero
  function automatic logic [31:0] svh_pack(input logic [15:0] svid,
                                           input logic [1:0] ctype,
                                           input logic [2:0] obj,
                                           input logic [4:0] cmd);
    logic [31:0] h;
    h = '0;
    h[31:16] = svid;
    h[SVH_TYPE_BIT] = 1'b1;
    h[14:13] = SVH_VER_SUPPORTED;
    h[10:8] = uses_obj(cmd) ? obj : SVH_OBJ_NONE;
    h[7:6] = ctype;
    h[4:0] = cmd;
    return h;
  endfunction : svh_pack

  // enter with the exit-all position and reserved position zero are malformed
  function automatic logic obj_ok(input logic [4:0] cmd, input logic [2:0] obj);
    if (!uses_obj(cmd)) return 1'b1;
    if (obj == SVH_OBJ_NONE) return 1'b0;
    return !(cmd == SVH_CMD_ENTER && obj == SVH_OBJ_EXIT_ALL);
  endfunction : obj_ok

endpackage : svh_pkg

// ---- hdl/svh_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface svh_link_if;
  logic dn_valid;
  logic [31:0] dn_hdr;
  logic [1:0] dn_sop;
  logic up_valid;
  logic [31:0] up_hdr;
  logic [1:0] up_sop;

  modport port_end (output dn_valid, output dn_hdr, output dn_sop,
                    input up_valid, input up_hdr, input up_sop);
  modport partner_end (input dn_valid, input dn_hdr, input dn_sop,
                       output up_valid, output up_hdr, output up_sop);
endinterface : svh_link_if
`default_nettype wire

// ---- hdl/svh_partner_end.sv ----
`timescale 1ns/100ps
`default_nettype none
// far party: a ufp or a cable plug answering requests
module svh_partner_end
  import svh_pkg::*;
(
  input wire logic clock_i, // 25 MHz
  input wire logic reset_i, // sync, active high
  input wire logic contract_i, // explicit contract in place
  input wire logic is_cable_i, // acts as cable plug, else ufp
  input wire logic support_i, // structured messages supported
  input wire logic abort_i, // other sop sequence takes over
  input wire logic tx_valid_i, // send a header, one-cycle pulse
  input wire logic [15:0] tx_svid_i, // svid to send
  input wire logic [1:0] tx_ctype_i, // command type
  input wire logic [2:0] tx_obj_i, // object position
  input wire logic [4:0] tx_cmd_i, // command
  output logic pending_o, // request awaiting our answer
  output logic tx_reject_o, // send refused, pulse
  output logic rx_valid_o, // accepted request, pulse
  output logic [15:0] rx_svid_o, // received svid
  output logic [2:0] rx_obj_o, // received object position
  output logic [4:0] rx_cmd_o, // received command
  output logic [1:0] rx_sop_o, // received packet kind
  output logic rx_drop_o, // received header discarded, pulse
  output logic exit_all_o, // exit of all modes asked, pulse
  svh_link_if.partner_end link // toward port
);

  logic rx_ok;
  logic tx_ok;
  logic sop_mine;
  logic [4:0] rx_cmd;
  logic [2:0] rx_obj;

  assign rx_cmd = link.dn_hdr[SVH_CMD_LSB +: 5];
  assign rx_obj = link.dn_hdr[SVH_OBJ_LSB +: 3];
  // a cable plug listens on sop' only, a ufp on sop only
  assign sop_mine = is_cable_i ? (link.dn_sop == SVH_SOP_P) : (link.dn_sop == SVH_SOP);

  assign rx_ok = support_i && link.dn_hdr[SVH_TYPE_BIT] && sop_mine &&
                 link.dn_hdr[SVH_CTYPE_LSB +: 2] == SVH_CT_INIT &&
                 rx_cmd != SVH_CMD_RSVD && rx_cmd != SVH_CMD_ATTN &&
                 obj_ok(rx_cmd, rx_obj) && !abort_i &&
                 (contract_i || (is_cable_i && rx_cmd == SVH_CMD_DISC_ID));

  always_comb begin
    tx_ok = support_i && !abort_i && tx_cmd_i != SVH_CMD_RSVD && obj_ok(tx_cmd_i, tx_obj_i);
    if (tx_ctype_i == SVH_CT_INIT)
      tx_ok = tx_ok && contract_i && !is_cable_i && tx_cmd_i == SVH_CMD_ATTN;
    else
      tx_ok = tx_ok && pending_o && tx_cmd_i == rx_cmd_o;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i)
      pending_o <= 1'b0;
    else if (abort_i)
      pending_o <= 1'b0;
    else if (link.dn_valid && rx_ok)
      pending_o <= 1'b1;
    else if (tx_valid_i && tx_ok && tx_ctype_i != SVH_CT_INIT)
      pending_o <= 1'b0;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      link.up_valid <= 1'b0;
      link.up_hdr <= SVH_HDR_RESET;
      link.up_sop <= SVH_SOP;
      tx_reject_o <= 1'b0;
    end else begin
      link.up_valid <= tx_valid_i && tx_ok;
      tx_reject_o <= tx_valid_i && !tx_ok;
      if (tx_valid_i && tx_ok) begin
        link.up_hdr <= svh_pack(tx_svid_i, tx_ctype_i, tx_obj_i, tx_cmd_i);
        link.up_sop <= (tx_ctype_i == SVH_CT_INIT) ? SVH_SOP : rx_sop_o;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_valid_o <= 1'b0;
      rx_drop_o <= 1'b0;
      exit_all_o <= 1'b0;
      rx_svid_o <= 16'h0000;
      rx_obj_o <= SVH_OBJ_NONE;
      rx_cmd_o <= SVH_CMD_RSVD;
      rx_sop_o <= SVH_SOP;
    end else begin
      rx_valid_o <= link.dn_valid && rx_ok;
      rx_drop_o <= link.dn_valid && !rx_ok;
      exit_all_o <= link.dn_valid && rx_ok && rx_cmd == SVH_CMD_EXIT &&
                    rx_obj == SVH_OBJ_EXIT_ALL;
      if (link.dn_valid && rx_ok) begin
        rx_svid_o <= link.dn_hdr[SVH_SVID_LSB +: 16];
        rx_obj_o <= rx_obj;
        rx_cmd_o <= rx_cmd;
        rx_sop_o <= link.dn_sop;
      end
    end
  end

endmodule : svh_partner_end
`default_nettype wire

// ---- tb/svh_link_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module svh_link_props (
  input wire logic clock_i, // bench clock
  input wire logic reset_i, // sync, active high
  input wire logic dn_valid, // port to partner
  input wire logic [31:0] dn_hdr, // header
  input wire logic [1:0] dn_sop, // packet kind
  input wire logic up_valid, // partner to port
  input wire logic [31:0] up_hdr, // header
  input wire logic [1:0] up_sop // packet kind
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [4:0] req_cmd_q;
  // remembers the request that an answer has to match
  always_ff @(posedge clock_i) begin
    if (reset_i) req_cmd_q <= 5'h00;
    else if (dn_valid && dn_hdr[7:6] == 2'h0) req_cmd_q <= dn_hdr[4:0];
  end
  sequence s_req;
    dn_valid && dn_hdr[7:6] == 2'h0 && dn_hdr[4:0] != 5'h06;
  endsequence
  property p_type; dn_valid |-> dn_hdr[15]; endproperty
  a_type: assert property (p_type) else $error("type bit clear");
  property p_ver; dn_valid |-> dn_hdr[14:13] == 2'h0; endproperty
  a_ver: assert property (p_ver) else $error("version not zero");
  property p_rsv; dn_valid |-> dn_hdr[12:11] == 2'h0 && !dn_hdr[5]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_unused; up_valid && !(up_hdr[4:0] inside {5'h04, 5'h05}) |-> up_hdr[10:8] == 3'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("stray position");
  property p_pos; dn_valid && dn_hdr[4:0] inside {5'h04, 5'h05} |-> dn_hdr[10:8] != 3'h0;
  endproperty
  a_pos: assert property (p_pos) else $error("position zero");
  property p_enter; dn_valid && dn_hdr[4:0] == 5'h04 |-> dn_hdr[10:8] != 3'h7; endproperty
  a_enter: assert property (p_enter) else $error("enter with exit-all");
  property p_cmd; dn_valid |-> dn_hdr[4:0] inside {[5'h01:5'h06]}; endproperty
  a_cmd: assert property (p_cmd) else $error("bad command");
  property p_up_fmt; up_valid |-> up_hdr[15:13] == 3'h4 && up_hdr[12:11] == 2'h0; endproperty
  a_up_fmt: assert property (p_up_fmt) else $error("answer format");
  property p_up_init; up_valid && up_hdr[7:6] == 2'h0 |-> up_hdr[4:0] == 5'h06 && up_sop == 2'h0;
  endproperty
  a_up_init: assert property (p_up_init) else $error("partner initiated");
  property p_resp; up_valid && up_hdr[7:6] != 2'h0 |-> up_hdr[4:0] == req_cmd_q; endproperty
  a_resp: assert property (p_resp) else $error("answer mismatch");
  property p_gap; s_req |=> !up_valid; endproperty
  a_gap: assert property (p_gap) else $error("answer too early");
  c_req: cover property (s_req ##[2:4] up_valid);
endmodule : svh_link_props
`default_nettype wire

// ---- tb/structured_vdm_header_logic_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module structured_vdm_header_logic_bench;
  import svh_pkg::*;
  logic clk = 0, rst = 1, ctr = 1, dfp = 1, src = 1, psup = 1, pab = 0, tv = 0;
  logic cab = 0, qsup = 1, qab = 0, qv = 0;
  logic [15:0] sv = 0, qsv = 0, a_sv, prsv, qrsv;
  logic [1:0] ct = 0, sop = 0, qct = 0, a_sop, prct, prver, prsop, qrsop;
  logic [2:0] ob = 0, qob = 0, a_ob, prob, qrob;
  logic [4:0] cm = 0, qcm = 0, a_cm, prcm, qrcm;
  logic busy, prj, prv, pdrop, pex, pend, qrj, qrv, qdrop, qex;
  logic [31:0] rnd = 32'h6935cd43;
  int n_mismatch = 0, n_checks = 0;
  int exp_q[$];
  always #20 clk = ~clk;
  svh_link_if link ();
  svh_port_end u_svh_port_end (.clock_i(clk), .reset_i(rst), .contract_i(ctr),
    .is_dfp_i(dfp), .is_source_i(src), .support_i(psup), .abort_i(pab), .tx_valid_i(tv),
    .tx_svid_i(sv), .tx_ctype_i(ct), .tx_obj_i(ob), .tx_cmd_i(cm), .tx_sop_i(sop),
    .busy_o(busy), .tx_reject_o(prj), .rx_valid_o(prv), .rx_svid_o(prsv), .rx_ctype_o(prct),
    .rx_obj_o(prob), .rx_cmd_o(prcm), .rx_ver_o(prver), .rx_sop_o(prsop), .rx_drop_o(pdrop),
    .exit_all_o(pex), .link(link));
  svh_partner_end u_svh_partner_end (.clock_i(clk), .reset_i(rst), .contract_i(ctr),
    .is_cable_i(cab), .support_i(qsup), .abort_i(qab), .tx_valid_i(qv), .tx_svid_i(qsv),
    .tx_ctype_i(qct), .tx_obj_i(qob), .tx_cmd_i(qcm), .pending_o(pend), .tx_reject_o(qrj),
    .rx_valid_o(qrv), .rx_svid_o(qrsv), .rx_obj_o(qrob), .rx_cmd_o(qrcm), .rx_sop_o(qrsop),
    .rx_drop_o(qdrop), .exit_all_o(qex), .link(link));
  svh_link_props u_props (.clock_i(clk), .reset_i(rst), .dn_valid(link.dn_valid),
    .dn_hdr(link.dn_hdr), .dn_sop(link.dn_sop), .up_valid(link.up_valid),
    .up_hdr(link.up_hdr), .up_sop(link.up_sop));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [31:0] hdr(input logic [15:0] s, input logic [1:0] t,
                                      input logic [2:0] o, input logic [4:0] c);
    return {s, 3'h4, 2'h0, (c == 5'h04 || c == 5'h05) ? o : 3'h0, t, 1'b0, c};
  endfunction : hdr
  function automatic logic pos_ok(input logic [4:0] c, input logic [2:0] o);
    if (c != 5'h04 && c != 5'h05) return 1'b1;
    return o != 3'h0 && !(c == 5'h04 && o == 3'h7);
  endfunction : pos_ok
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // port request; k is what the model predicts
  task automatic req(input logic [4:0] c, input logic [2:0] o, input logic [1:0] s,
                     input logic k);
    rnd = nx(rnd);
    tv = 1; cm = c; ob = o; sop = s; ct = SVH_CT_INIT; sv = rnd[15:0];
    @(negedge clk) tv = 0;
    chk(link.dn_valid, k);
    chk(prj, !k);
    if (k) begin
      a_sv = sv; a_cm = c; a_ob = o; a_sop = s;
      exp_q.push_back(c);
      chk(link.dn_hdr, hdr(sv, SVH_CT_INIT, o, c));
      chk(busy, 1);
    end
    @(negedge clk);
    chk(qrv, k && qsup);
    if (k && qsup) begin
      chk(qrcm, c);
      chk(qrsv, a_sv);
      chk(qrob, (c == 5'h04 || c == 5'h05) ? o : 3'h0);
      chk(qrsop, s);
      chk(qex, c == 5'h05 && o == 3'h7);
    end
    if (k && !qsup) chk(qdrop, 1);
  endtask : req
  task automatic ans(input logic [1:0] t);
    qv = 1; qct = t; qcm = a_cm; qsv = a_sv; qob = a_ob;
    @(negedge clk) qv = 0;
    chk(link.up_hdr, hdr(a_sv, t, a_ob, a_cm));
    chk(link.up_valid, 1);
    chk(qrj, 0);
    @(negedge clk);
    chk(prv, 1);
    chk(prct, t);
    if (t != SVH_CT_INIT) chk(prcm, exp_q.pop_front());
    else chk(prcm, a_cm);
    chk(prsv, a_sv);
    chk(prob, (a_cm == 5'h04 || a_cm == 5'h05) ? a_ob : 3'h0);
    chk(pex, a_cm == 5'h05 && a_ob == 3'h7);
    chk(pdrop, 0);
    chk(prsop, a_sop);
    chk(prver, SVH_VER_1_0);
    chk(busy, 0);
    chk(pend, 0);
  endtask : ans
  task automatic abt();
    pab = 1; qab = 1;
    @(negedge clk) pab = 0;
    qab = 0;
    exp_q.delete();
    chk(busy, 0);
    chk(pend, 0);
  endtask : abt
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [4:0] c;
    logic [2:0] o;
    logic k;
    repeat (16) @(negedge clk);
    rst = 0;
    chk(busy, 0);
    for (int i = 0; i < 15; i++) begin
      c = 5'(1 + i % 5);
      rnd = nx(rnd);
      o = rnd[2:0];
      k = pos_ok(c, o);
      req(c, o, SVH_SOP, k);
      if (k) ans(2'(1 + i % 3));
    end
    req(SVH_CMD_ENTER, 3'h7, SVH_SOP, 0);
    req(SVH_CMD_EXIT, 3'h0, SVH_SOP, 0);
    req(SVH_CMD_EXIT, 3'h7, SVH_SOP, 1);
    ans(SVH_CT_ACK);
    req(SVH_CMD_DISC_SVIDS, 3'h0, SVH_SOP, 1);
    req(SVH_CMD_DISC_MODES, 3'h0, SVH_SOP, 0);
    abt();
    qsup = 0;
    req(SVH_CMD_DISC_SVIDS, 3'h0, SVH_SOP, 1);
    abt();
    qsup = 1;
    ctr = 0;
    cab = 1;
    req(SVH_CMD_DISC_SVIDS, 3'h0, SVH_SOP_P, 0);
    req(SVH_CMD_DISC_ID, 3'h0, SVH_SOP_P, 1);
    ans(SVH_CT_ACK);
    ctr = 1;
    cab = 0;
    dfp = 0;
    req(SVH_CMD_DISC_ID, 3'h0, SVH_SOP, 0);
    dfp = 1;
    psup = 0;
    req(SVH_CMD_DISC_ID, 3'h0, SVH_SOP, 0);
    psup = 1;
    // attention comes only from the far side
    rnd = nx(rnd);
    a_sv = rnd[15:0]; a_cm = SVH_CMD_ATTN; a_ob = 3'h0; a_sop = SVH_SOP;
    ans(SVH_CT_INIT);
    // no exchange is open, so an answer is refused
    qv = 1; qct = SVH_CT_ACK;
    @(negedge clk) qv = 0;
    chk(qrj, 1);
    chk(link.up_valid, 0);
    // a port without support drops even a well-formed attention
    @(negedge clk) psup = 0;
    qv = 1; qct = SVH_CT_INIT;
    @(negedge clk) qv = 0;
    @(negedge clk);
    chk(pdrop, 1);
    chk(prv, 0);
    psup = 1;
    chk(exp_q.size(), 0);
    finish_test();
  end
endmodule : structured_vdm_header_logic_bench
`default_nettype wire
